// ==== src/pulse_switch.sv ====
`timescale 1ns/100ps
`include "pulse_switch_defines.svh"

// Notes on behaviour
// - A trigger rising edge while the output is off turns the output on and restarts elapsed time from zero.
// - When elapsed time equals the off-delay and continuous mode is off, the output drops.
// - Reset (power loss) clears the elapsed time so no timing carries over.
// - A trigger held for at least the hold time enters continuous mode, output stays on.
// - A new rising edge while the output is on clears timing and switches the output off.
module multifunction_pulse_switch
    import pulse_switch_pkg::*;
#(
    parameter logic [31:0] TICK_DIV = `TICK_DIV_DEFAULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Trigger and configuration
    input wire logic trg_i,
    input wire sw_cfg_t cfg_i,
    // Results
    output logic out_o,
    output logic cont_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    sw_regs_t r_q;
    sw_regs_t r_d;
    logic cycle_tick;
    logic rise;

    // ----------------------------------------
    // Program cycle and edge detection
    // ----------------------------------------
    // Program cycle strobe; the trigger is only looked at on it
    // A slow tick keeps the time counts short, but a pulse between two ticks is lost
    assign cycle_tick = (r_q.div == TICK_DIV - 32'h0000_0001);
    assign rise = trg_i & ~r_q.trg_prev;

    // ----------------------------------------
    // Switch state machine
    // ----------------------------------------
    // Next-state logic
    // The hold test comes before the timeout, so a long press beats the off-delay
    always_comb begin
        r_d = r_q;
        if (cycle_tick) begin
            r_d.div = 32'h0000_0000;
        end else begin
            r_d.div = r_q.div + 32'h0000_0001;
        end
        if (cycle_tick) begin
            r_d.trg_prev = trg_i;
            // Held flag drops at the first tick that sees the trigger released
            r_d.held = r_q.held & trg_i;
            case (r_q.state)
                ST_OFF: begin
                    if (rise) begin
                        r_d.state = ST_DELAY;
                        r_d.out = 1'b1;
                        r_d.elapsed = 32'h0000_0000;
                        r_d.held = 1'b1;
                    end
                end
                ST_DELAY: begin
                    r_d.elapsed = r_q.elapsed + 32'h0000_0001;
                    if (rise) begin
                        // Second press wins over any timeout in the same cycle
                        r_d.state = ST_OFF;
                        r_d.out = 1'b0;
                        r_d.elapsed = 32'h0000_0000;
                    end else if (r_q.held && trg_i && r_d.elapsed >= cfg_i.hold_time) begin
                        r_d.state = ST_CONT;
                        r_d.cont = 1'b1;
                    end else if (r_d.elapsed == cfg_i.off_delay) begin
                        r_d.state = ST_OFF;
                        r_d.out = 1'b0;
                    end
                end
                ST_CONT: begin
                    if (rise) begin
                        r_d.state = ST_OFF;
                        r_d.out = 1'b0;
                        r_d.cont = 1'b0;
                        r_d.elapsed = 32'h0000_0000;
                    end
                end
                default: begin
                    r_d.state = ST_OFF;
                    r_d.out = 1'b0;
                    r_d.cont = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers and outputs
    // ----------------------------------------
    // Reset models power loss: everything including elapsed time clears
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_q <= '{state: ST_OFF, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs come straight from the state register
    assign out_o = r_q.out;
    assign cont_o = r_q.cont;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_rise_on;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && rise && r_q.state == ST_OFF) |=> (out_o && r_q.elapsed == 32'h0000_0000);
    endproperty
    a_rise_on: assert property (p_rise_on) else $error("rise did not start");

    property p_timeout;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && r_q.state == ST_DELAY && !rise && !(r_q.held && trg_i)
         && r_q.elapsed + 32'h0000_0001 == cfg_i.off_delay) |=> !out_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no timeout");

    property p_reset_clear;
        @(posedge clk_i) !rst_b_i |-> (r_q.elapsed == 32'h0000_0000 && !out_o);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left time");

    property p_cont_stays;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cont_o && !(cycle_tick && rise)) |=> (cont_o && out_o);
    endproperty
    a_cont_stays: assert property (p_cont_stays) else $error("continuous dropped");

    property p_press_off;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && rise && out_o) |=> (!out_o && !cont_o);
    endproperty
    a_press_off: assert property (p_press_off) else $error("press did not switch off");

    property p_sample_only_tick;
        @(posedge clk_i) disable iff (!rst_b_i)
        !cycle_tick |=> $stable(r_q.trg_prev) && $stable(out_o);
    endproperty
    a_sample_only_tick: assert property (p_sample_only_tick)
        else $error("off-tick change");

    // Elapsed time moves only on a program-cycle tick
    property p_elapsed_still;
        @(posedge clk_i) disable iff (!rst_b_i)
        !cycle_tick |=> $stable(r_q.elapsed);
    endproperty
    a_elapsed_still: assert property (p_elapsed_still)
        else $error("elapsed moved off tick");

    // The divider wraps at its end value, so ticks stay evenly spaced
    property p_div_range;
        @(posedge clk_i) disable iff (!rst_b_i)
        r_q.div <= TICK_DIV - 32'h0000_0001;
    endproperty
    a_div_range: assert property (p_div_range)
        else $error("divider out of range");

    // Every tick in delay mode without a new press adds one to elapsed time
    property p_delay_count;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && r_q.state == ST_DELAY && !rise)
        |=> (r_q.elapsed == $past(r_q.elapsed) + 32'h0000_0001);
    endproperty
    a_delay_count: assert property (p_delay_count)
        else $error("elapsed did not count");

    // A press held past the hold time enters continuous mode before any timeout
    property p_cont_enter;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && r_q.state == ST_DELAY && !rise && r_q.held && trg_i
         && r_q.elapsed + 32'h0000_0001 >= cfg_i.hold_time) |=> (cont_o && out_o);
    endproperty
    a_cont_enter: assert property (p_cont_enter)
        else $error("continuous not entered");

    // Continuous mode never shows with the output off
    property p_cont_needs_out;
        @(posedge clk_i) disable iff (!rst_b_i)
        cont_o |-> out_o;
    endproperty
    a_cont_needs_out: assert property (p_cont_needs_out)
        else $error("continuous without output");

    // Output is on in delay and continuous mode only
    property p_out_state;
        @(posedge clk_i) disable iff (!rst_b_i)
        out_o == (r_q.state != ST_OFF);
    endproperty
    a_out_state: assert property (p_out_state)
        else $error("output and state disagree");

    // With no rise the off state stays off; a stray wake-up would switch a load on
    property p_off_stays;
        @(posedge clk_i) disable iff (!rst_b_i)
        (r_q.state == ST_OFF && !(cycle_tick && rise)) |=> !out_o;
    endproperty
    a_off_stays: assert property (p_off_stays)
        else $error("output on without a press");

    // A press in delay mode clears the timing and returns to the off state
    property p_delay_press_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && rise && r_q.state == ST_DELAY)
        |=> (r_q.elapsed == 32'h0000_0000 && r_q.state == ST_OFF);
    endproperty
    a_delay_press_clear: assert property (p_delay_press_clear)
        else $error("delay press left timing");

    // A press in continuous mode leaves no elapsed time behind for the next press
    property p_cont_press_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cycle_tick && rise && r_q.state == ST_CONT)
        |=> (r_q.elapsed == 32'h0000_0000 && r_q.state == ST_OFF);
    endproperty
    a_cont_press_clear: assert property (p_cont_press_clear)
        else $error("continuous press left timing");

    // Power loss also clears the divider, so the first tick is a full cycle away
    property p_reset_div;
        @(posedge clk_i) !rst_b_i |-> (r_q.div == 32'h0000_0000 && !cont_o);
    endproperty
    a_reset_div: assert property (p_reset_div)
        else $error("reset left divider or mode");

    // The state register holds exactly one state code
    property p_state_onehot;
        @(posedge clk_i) disable iff (!rst_b_i)
        $onehot(r_q.state);
    endproperty
    a_state_onehot: assert property (p_state_onehot)
        else $error("state code not one-hot");

endmodule // multifunction_pulse_switch

// ==== inc/pulse_switch_defines.svh ====
`ifndef PULSE_SWITCH_DEFINES_SVH
`define PULSE_SWITCH_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define TIME_W 32
`define TICK_DIV_DEFAULT 32'h0000_0004
`define MIN_SETTING_TICKS 32'h0000_0002

`endif

// ==== inc/pulse_switch_pkg.sv ====
package pulse_switch_pkg;

    // Switch states, one-hot
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_DELAY = 3'b010,
        ST_CONT = 3'b100
    } sw_state_t;

    // Configured times in ticks
    typedef struct packed {
        logic [31:0] off_delay;
        logic [31:0] hold_time;
    } sw_cfg_t;

    // Whole block state
    typedef struct packed {
        sw_state_t state;
        logic trg_prev;
        logic held;
        logic [31:0] elapsed;
        logic [31:0] div;
        logic out;
        logic cont;
    } sw_regs_t;

endpackage

// ==== dv/trigger_source.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Trigger source of the surrounding program
// ----------------------------------------
module trigger_source (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Press request
    input wire logic go_i,
    input wire logic [7:0] len_i,
    // Trigger level
    output logic trg_o
);
    logic [7:0] cnt_q;
    // Level holds for len_i clocks; a short press may fall between ticks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) cnt_q <= 8'h00;
        else if (go_i) cnt_q <= len_i;
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
    assign trg_o = (cnt_q != 8'h00);
endmodule // trigger_source

// ==== dv/multifunction_pulse_switch_tb_top.sv ====
`timescale 1ns/100ps
module multifunction_pulse_switch_tb_top;
    import pulse_switch_pkg::*;
    logic clk_i = 1'b0, rst_b_i, go = 1'b0, trg, out_o, cont_o;
    logic [7:0] len = 8'h00;
    sw_cfg_t cfg_i = '{off_delay: 32'h0000_0006, hold_time: 32'h0000_0004};
    int miscompares = 0, checks_done = 0;
    initial forever #2 clk_i = ~clk_i;
    trigger_source trigger_source_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go),
        .len_i(len), .trg_o(trg));
    multifunction_pulse_switch multifunction_pulse_switch_i (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .trg_i(trg), .cfg_i(cfg_i), .out_o(out_o), .cont_o(cont_o));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic press(input logic [7:0] n);
        go <= 1'b1;
        len <= n;
        cyc(1);
        go <= 1'b0;
    endtask
    // Bounded wait: output must follow a taken rise within 16 clocks (four ticks)
    task automatic wait_on();
        int i;
        for (i = 0; i < 16 && out_o !== 1'b1; i++) cyc(1);
        if (i == 16) begin
            chk("out_on_wait", out_o, 1'b1);
            wrap_up();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_delay();
        press(8'h08);
        wait_on();
        chk("cont_short", cont_o, 1'b0);
        cyc(40);
        chk("out_timeout", out_o, 1'b0);
    endtask
    task automatic sc_retrigger();
        press(8'h08);
        wait_on();
        cyc(12);
        press(8'h08);
        cyc(4);
        chk("out_retrig", out_o, 1'b0);
        cyc(40);
    endtask
    task automatic sc_cont();
        press(8'h50);
        cyc(120);
        chk("out_cont", out_o, 1'b1);
        chk("cont_on", cont_o, 1'b1);
        press(8'h08);
        cyc(12);
        chk("out_cont_off", out_o, 1'b0);
        chk("cont_off", cont_o, 1'b0);
        cyc(40);
    endtask
    // Power loss mid-timing, then a fresh press must still be on 16 clocks after turning on
    task automatic sc_power();
        press(8'h08);
        wait_on();
        rst_b_i <= 1'b0;
        cyc(2);
        chk("out_reset", out_o, 1'b0);
        rst_b_i <= 1'b1;
        cyc(2);
        press(8'h08);
        wait_on();
        cyc(16);
        chk("out_fresh", out_o, 1'b1);
        cyc(40);
    endtask
    initial begin
        rst_b_i <= 1'b0;
        cyc(4);
        rst_b_i <= 1'b1;
        cyc(2);
        sc_delay();
        sc_retrigger();
        sc_cont();
        sc_power();
        wrap_up();
    end
endmodule // multifunction_pulse_switch_tb_top
